// [rtl/bcwd_defs.vh]
// bcwd_defs.vh: offsets, field positions, reset values and timing for the bus cycle wait/delay control
// assumes byte-addressed apb with one aligned word per register
`ifndef BCWD_DEFS_VH
`define BCWD_DEFS_VH
// register indexes as printed; byte address is four times the index
`define BCWD_IDX_MMWAIT2     8'h50
`define BCWD_IDX_CMDDELAY    8'h60
`define BCWD_IDX_IOWAIT      8'h61
`define BCWD_IDX_MMWAIT1     8'h62
`define BCWD_IDX_WAITCTL     8'h63
`define BCWD_IDX_MISC5       8'hb3
`define BCWD_IDX_ROMCFG3     8'hb8
`define BCWD_IDX_STATUS      8'hc0
`define BCWD_RST_REG         8'h00
// misc_config_five fields
`define BCWD_M5_BIOS_DEC     2
`define BCWD_M5_BIOS_FAST    6
`define BCWD_M5_BIOS_WS_LO   4
// rom_config_three fields
`define BCWD_R3_DOS_DEC      4
`define BCWD_R3_DOS_FAST     7
`define BCWD_R3_DOS_WS_LO    5
// command_delay_control fields
`define BCWD_CD_HALF         2
`define BCWD_CD_IO_LO        0
`define BCWD_CD_BIOS_A       7
`define BCWD_CD_BIOS_B       4
// cycle type codes
`define BCWD_CY_MEM8_ISA     4'h0
`define BCWD_CY_MEM8_CARD    4'h1
`define BCWD_CY_MEM8_DOS     4'h2
`define BCWD_CY_MEM8_BIOS    4'h3
`define BCWD_CY_MEM8_BIOSW   4'h4
`define BCWD_CY_MEM16        4'h5
`define BCWD_CY_IO8_INT      4'h6
`define BCWD_CY_IO8_EXT      4'h7
`define BCWD_CY_IO16         4'h8
// slow clock period in fast clock cycles; 200 MHz / 9.2 MHz rounds down to 21
`define BCWD_CLK_MHZ         200
`define BCWD_SLOW_KHZ        9200
`define BCWD_SLOW_DIV        ((`BCWD_CLK_MHZ * 1000) / `BCWD_SLOW_KHZ)
`endif

// [rtl/bcwd_ctrl.v]
// bcwd_ctrl.v: wait-state and command-delay sequencer for external rom, card, bus memory and i/o cycles
// assumes a single 200 MHz clk; the bus clock is produced here as half-cycle ticks from clk
//
// What this block does
// - rom selects are gated by memory read or write command by default.
// - misc_config_five bit 2 set makes bios select a pure address decode.
// - rom_config_three bit 4 set makes dos select a pure address decode.
// - with cpu clock stopped both rom selects are forced high.
// - command delay shortens the command; cycle end stays at wait-state time.
// - 8-bit bus memory delay is 1 or 0.5 clock by command_delay_control bit 2.
// - 8-bit card and dos rom delay 0, 0.5 or 1 by 60h bit 2 and 50h bits.
// - fixed delay 0.5 for bios, internal i/o, 16-bit i/o; 0 for 16-bit memory.
// - 8-bit external i/o delay 0.5, 1 or 2 by 60h bits 1:0.
// - each wait state holds the command one more bus clock.
// - 8-bit bus memory and window bios take 2 to 5 waits from 62h bits 1:0.
// - 8-bit card and dos rom take 1 to 4 waits or bus setting from 50h.
// - non-window 8-bit bios takes 2 or 3 waits by 60h bits 7 and 4.
// - 16-bit memory other than a fast rom cycle takes 1 to 4 waits from 62h bits 3:2.
// - internal 8-bit i/o 2 or 4 waits by 63h bit 3; 16-bit i/o 3 or 4 by bit 2.
// - 8-bit external i/o waits 2 to 5 from 61h per floppy, drive and other ranges.
// - either rom select may run at the fast cpu clock rate.
// - misc_config_five bit 6 enables fast bios cycles; cleared by reset.
// - fast bios waits from misc_config_five bits 5:4: 4,3,2,1.
// - in full expansion bus mode no latch enable for fast bios cycles.
// - rom_config_three bit 7 enables fast dos cycles; cleared by reset.
// - fast dos waits from rom_config_three bits 6:5: 4,3,2,1.
`timescale 1ns/1ps
`default_nettype none
`include "bcwd_defs.vh"

module bcwd_ctrl #(
   parameter integer SLOW_DIV = `BCWD_SLOW_DIV   // clk cycles per bus clock period
) (
   input  wire        clk,            // 200 MHz clock
   input  wire        reset,          // synchronous, active high
   input  wire        psel,           // apb select
   input  wire        penable,        // apb access phase
   input  wire        pwrite,         // apb direction
   input  wire [11:0] paddr,          // apb byte address
   input  wire [31:0] pwdata,         // apb write data
   output reg  [31:0] prdata,         // apb read data
   output reg         pready,         // apb ready
   output reg         pslverr,        // apb error on unmapped address
   input  wire        cycStart,       // pulse: start an external cycle
   input  wire        cycWrite,       // cycle is a write
   input  wire        cycIo,          // cycle is i/o
   input  wire        cycWide,        // cycle is 16-bit
   input  wire        cycBiosRom,     // bios rom decode hit
   input  wire        cycDosRom,      // dos rom decode hit
   input  wire        cycCard,        // card memory window hit
   input  wire        cycWindow,      // bios reached through mapped_memory_window
   input  wire [15:0] cycAddr,        // i/o address
   input  wire        cpuClockStopped, // cpu clock stopped
   input  wire        fullExpansionBusMode, // full_expansion_bus_mode
   output reg         systemBusClock, // divided bus clock out
   output reg         addrLatchEnable, // address latch enable
   output reg         memRdCmdN,      // memory read command, low active
   output reg         memWrCmdN,      // memory write command, low active
   output reg         ioRdCmdN,       // i/o read command, low active
   output reg         ioWrCmdN,       // i/o write command, low active
   output reg         biosRomSelectN, // bios_rom_select, low active
   output reg         dosRomSelectN,  // dos_rom_select, low active
   output reg         cycDone         // pulse: cycle finished
);

   localparam integer HALF = (SLOW_DIV / 2 < 1) ? 1 : SLOW_DIV / 2;
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_ADDR = 2'd1;
   localparam [1:0] ST_CMD  = 2'd2;
   localparam [1:0] ST_END  = 2'd3;

   reg  [7:0]  mmWait2_q, cmdDelay_q, ioWait_q, mmWait1_q, waitCtl_q, misc5_q, romCfg3_q;
   reg  [15:0] divCnt_q;
   reg  [1:0]  state_q;
   reg  [4:0]  dlyCnt_q;    // delay in half bus clocks
   reg  [4:0]  runCnt_q;    // total half bus clocks from address to command end
   reg  [4:0]  dlyHalf_d;
   reg  [4:0]  runHalf_d;
   reg  [3:0]  cyType_q;
   reg         cyWrite_q, cyIo_q, cyBios_q, cyDos_q, cyFast_q;
   reg         cmdOn_q;
   wire [7:0]  regIdx = paddr[9:2];
   wire        halfTick;
   wire        apbAcc = psel & penable & ~pready;

   // a fast rom cycle steps at the cpu rate, one half clock per clk
   assign halfTick = cyFast_q | (divCnt_q == HALF[15:0] - 16'd1);

   // decode of printed waits from a two-bit field with given base
   function [2:0] ws2;
      input [1:0] f;
      input [2:0] base;
      begin
         ws2 = base + {1'b0, f};
      end
   endfunction

   // fast rom wait encoding 00->4 .. 11->1
   function [2:0] wsFast;
      input [1:0] f;
      begin
         wsFast = 3'd4 - {1'b0, f};
      end
   endfunction

   function [3:0] classify;
      input io;
      input wide;
      input bios;
      input dos;
      input card;
      input win;
      input [15:0] a;
      begin
         if (io)
            classify = wide ? `BCWD_CY_IO16 : (a < 16'h0100 ? `BCWD_CY_IO8_INT : `BCWD_CY_IO8_EXT);
         else if (wide)
            classify = `BCWD_CY_MEM16;
         else if (dos)
            classify = `BCWD_CY_MEM8_DOS;
         else if (bios)
            classify = win ? `BCWD_CY_MEM8_BIOSW : `BCWD_CY_MEM8_BIOS;
         else if (card)
            classify = `BCWD_CY_MEM8_CARD;
         else
            classify = `BCWD_CY_MEM8_ISA;
      end
   endfunction

   // delay and wait count for the cycle being started, in half bus clocks
   reg [3:0] ty;
   reg [2:0] ws;
   reg [2:0] dsel;
   always @* begin
      ty = classify(cycIo, cycWide, cycBiosRom, cycDosRom, cycCard, cycWindow, cycAddr);
      ws = 3'd1;
      dsel = 3'd1;
      case (ty)
         `BCWD_CY_MEM8_ISA: begin
            ws = ws2(mmWait1_q[1:0], 3'd2);
            dsel = cmdDelay_q[`BCWD_CD_HALF] ? 3'd1 : 3'd2;
         end
         `BCWD_CY_MEM8_BIOSW: begin
            ws = ws2(mmWait1_q[1:0], 3'd2);
            dsel = 3'd1;
         end
         `BCWD_CY_MEM8_BIOS: begin
            ws = (cmdDelay_q[`BCWD_CD_BIOS_A] | cmdDelay_q[`BCWD_CD_BIOS_B]) ? 3'd3 : 3'd2;
            dsel = 3'd1;
         end
         `BCWD_CY_MEM8_CARD: begin
            ws = mmWait2_q[5:3] > 3'd3 ? ws2(mmWait1_q[1:0], 3'd2) : mmWait2_q[5:3] + 3'd1;
            dsel = mmWait2_q[7] ? 3'd0 : (mmWait2_q[5] | cmdDelay_q[`BCWD_CD_HALF]) ? 3'd1 : 3'd2;
         end
         `BCWD_CY_MEM8_DOS: begin
            ws = mmWait2_q[2:0] > 3'd3 ? ws2(mmWait1_q[1:0], 3'd2) : mmWait2_q[2:0] + 3'd1;
            dsel = mmWait2_q[6] ? 3'd0 : (mmWait2_q[2] | cmdDelay_q[`BCWD_CD_HALF]) ? 3'd1 : 3'd2;
         end
         `BCWD_CY_MEM16: begin
            ws = ws2(mmWait1_q[3:2], 3'd1);
            dsel = 3'd0;
         end
         `BCWD_CY_IO8_INT: begin
            ws = waitCtl_q[3] ? 3'd4 : 3'd2;
            dsel = 3'd1;
         end
         `BCWD_CY_IO8_EXT: begin
            if (cycAddr[15:3] == 13'h007e)
               ws = ws2(ioWait_q[1:0], 3'd2);
            else if (cycAddr[15:3] == 13'h003e)
               ws = ws2(ioWait_q[3:2], 3'd2);
            else
               ws = ws2(ioWait_q[5:4], 3'd2);
            case (cmdDelay_q[1:0])
               2'b00:   dsel = 3'd1;
               2'b01:   dsel = 3'd2;
               default: dsel = 3'd4;
            endcase
         end
         `BCWD_CY_IO16: begin
            ws = waitCtl_q[2] ? 3'd4 : 3'd3;
            dsel = 3'd1;
         end
         default: begin
            ws = 3'd1;
            dsel = 3'd0;
         end
      endcase
      if (!cycIo && !cycWide && cycBiosRom && misc5_q[`BCWD_M5_BIOS_FAST])
         ws = wsFast(misc5_q[5:4]);
      else if (!cycIo && cycDosRom && romCfg3_q[`BCWD_R3_DOS_FAST])
         ws = wsFast(romCfg3_q[6:5]);
      if (!cycIo && cycBiosRom && misc5_q[`BCWD_M5_BIOS_FAST])
         ws = wsFast(misc5_q[5:4]);
      dlyHalf_d = {2'b00, dsel};
      // base command length two bus clocks plus one per wait state
      runHalf_d = 5'd4 + {1'b0, ws, 1'b0};
   end

   // apb slave, one wait cycle; registers at index*4
   always @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         mmWait2_q <= `BCWD_RST_REG;
         cmdDelay_q <= `BCWD_RST_REG;
         ioWait_q <= `BCWD_RST_REG;
         mmWait1_q <= `BCWD_RST_REG;
         waitCtl_q <= `BCWD_RST_REG;
         misc5_q <= `BCWD_RST_REG;
         romCfg3_q <= `BCWD_RST_REG;
      end else begin
         pready <= apbAcc;
         pslverr <= 1'b0;
         if (apbAcc) begin
            prdata <= 32'h00000000;
            case (regIdx)
               `BCWD_IDX_MMWAIT2:  if (pwrite) mmWait2_q <= pwdata[7:0];  else prdata[7:0] <= mmWait2_q;
               `BCWD_IDX_CMDDELAY: if (pwrite) cmdDelay_q <= pwdata[7:0]; else prdata[7:0] <= cmdDelay_q;
               `BCWD_IDX_IOWAIT:   if (pwrite) ioWait_q <= pwdata[7:0];   else prdata[7:0] <= ioWait_q;
               `BCWD_IDX_MMWAIT1:  if (pwrite) mmWait1_q <= pwdata[7:0];  else prdata[7:0] <= mmWait1_q;
               `BCWD_IDX_WAITCTL:  if (pwrite) waitCtl_q <= pwdata[7:0];  else prdata[7:0] <= waitCtl_q;
               `BCWD_IDX_MISC5:    if (pwrite) misc5_q <= pwdata[7:0];    else prdata[7:0] <= misc5_q;
               `BCWD_IDX_ROMCFG3:  if (pwrite) romCfg3_q <= pwdata[7:0];  else prdata[7:0] <= romCfg3_q;
               `BCWD_IDX_STATUS:   prdata[7:0] <= {cmdOn_q, cyFast_q, state_q, cyType_q};
               default:            pslverr <= 1'b1;
            endcase
            if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
               pslverr <= 1'b1;
         end
      end
   end

   // bus clock divider; free-running, while a fast cycle steps on every clk instead
   always @(posedge clk) begin
      if (reset) begin
         divCnt_q <= 16'h0000;
         systemBusClock <= 1'b0;
      end else if (divCnt_q == HALF[15:0] - 16'd1) begin
         divCnt_q <= 16'h0000;
         systemBusClock <= ~systemBusClock;
      end else begin
         divCnt_q <= divCnt_q + 16'h0001;
      end
   end

   // cycle sequencer in half bus clock steps so half delays land on the opposite edge
   always @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         dlyCnt_q <= 5'h00;
         runCnt_q <= 5'h00;
         cyType_q <= 4'h0;
         cyWrite_q <= 1'b0;
         cyIo_q <= 1'b0;
         cyBios_q <= 1'b0;
         cyDos_q <= 1'b0;
         cyFast_q <= 1'b0;
         cmdOn_q <= 1'b0;
         cycDone <= 1'b0;
         addrLatchEnable <= 1'b0;
      end else begin
         cycDone <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (cycStart) begin
                  cyType_q <= ty;
                  cyWrite_q <= cycWrite;
                  cyIo_q <= cycIo;
                  cyBios_q <= cycBiosRom & ~cycIo;
                  cyDos_q <= cycDosRom & ~cycIo;
                  cyFast_q <= ~cycIo & ((cycBiosRom & misc5_q[`BCWD_M5_BIOS_FAST]) |
                              (cycDosRom & romCfg3_q[`BCWD_R3_DOS_FAST]));
                  dlyCnt_q <= dlyHalf_d;
                  runCnt_q <= runHalf_d;
                  // latch enable suppressed for fast bios cycles in full bus mode
                  addrLatchEnable <= ~(fullExpansionBusMode & ~cycIo & cycBiosRom &
                                     misc5_q[`BCWD_M5_BIOS_FAST]);
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (halfTick) begin
                  addrLatchEnable <= 1'b0;
                  runCnt_q <= runCnt_q - 5'd1;
                  if (dlyCnt_q <= 5'd1) begin
                     cmdOn_q <= 1'b1;
                     state_q <= ST_CMD;
                  end else begin
                     dlyCnt_q <= dlyCnt_q - 5'd1;
                  end
               end else if (dlyCnt_q == 5'd0) begin
                  addrLatchEnable <= 1'b0;
                  cmdOn_q <= 1'b1;
                  state_q <= ST_CMD;
               end
            end
            ST_CMD: begin
               // end point counted from the address phase, not from command start
               if (halfTick) begin
                  if (runCnt_q <= 5'd1) begin
                     cmdOn_q <= 1'b0;
                     state_q <= ST_END;
                  end else begin
                     runCnt_q <= runCnt_q - 5'd1;
                  end
               end
            end
            ST_END: begin
               cycDone <= 1'b1;
               cyFast_q <= 1'b0;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // command and select outputs straight from flops
   always @(posedge clk) begin
      if (reset) begin
         memRdCmdN <= 1'b1;
         memWrCmdN <= 1'b1;
         ioRdCmdN <= 1'b1;
         ioWrCmdN <= 1'b1;
         biosRomSelectN <= 1'b1;
         dosRomSelectN <= 1'b1;
      end else begin
         memRdCmdN <= ~(cmdOn_q & ~cyIo_q & ~cyWrite_q);
         memWrCmdN <= ~(cmdOn_q & ~cyIo_q & cyWrite_q);
         ioRdCmdN <= ~(cmdOn_q & cyIo_q & ~cyWrite_q);
         ioWrCmdN <= ~(cmdOn_q & cyIo_q & cyWrite_q);
         if (cpuClockStopped) begin
            biosRomSelectN <= 1'b1;
            dosRomSelectN <= 1'b1;
         end else begin
            biosRomSelectN <= ~(cyBios_q & (state_q != ST_IDLE) &
                              (misc5_q[`BCWD_M5_BIOS_DEC] | cmdOn_q));
            dosRomSelectN <= ~(cyDos_q & (state_q != ST_IDLE) &
                             (romCfg3_q[`BCWD_R3_DOS_DEC] | cmdOn_q));
         end
      end
   end

endmodule // bcwd_ctrl
`default_nettype wire

// [verification/bcwd_monitor.sv]
// bcwd_monitor.sv: port assertions for the wait-state and command-delay sequencer
// assumes it is bound into bcwd_ctrl; rom settings are mirrored from apb writes
`timescale 1ns/1ps
`default_nettype none
module bcwd_monitor #(
   parameter integer SLOW_DIV = 21  // clk cycles per bus clock
) (
   input wire logic        clk,                  // clock
   input wire logic        reset,                // sync reset
   input wire logic        psel,                 // apb
   input wire logic        penable,              // apb
   input wire logic        pwrite,               // apb
   input wire logic [11:0] paddr,                // apb
   input wire logic [31:0] pwdata,               // apb
   input wire logic        pready,               // apb
   input wire logic        pslverr,              // apb
   input wire logic        cycStart,             // cycle request
   input wire logic        cycIo,                // i/o cycle
   input wire logic        cycBiosRom,           // bios hit
   input wire logic        cycDosRom,            // dos hit
   input wire logic        cpuClockStopped,      // cpu stop
   input wire logic        fullExpansionBusMode, // full bus mode
   input wire logic        addrLatchEnable,      // latch enable
   input wire logic        memRdCmdN,            // command
   input wire logic        memWrCmdN,            // command
   input wire logic        ioRdCmdN,             // command
   input wire logic        ioWrCmdN,             // command
   input wire logic        biosRomSelectN,       // select
   input wire logic        dosRomSelectN,        // select
   input wire logic        cycDone               // cycle end
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] misc5_q, romCfg3_q;
   logic       busy_q, rom_q, fast_q;
   wire        apbWr   = psel & penable & pready & pwrite & ~pslverr;
   wire        take    = cycStart & ~busy_q;
   wire        cmdIdle = memRdCmdN & memWrCmdN & ioRdCmdN & ioWrCmdN;
   wire        fastNow = ~cycIo & cycBiosRom & misc5_q[6];
   // the gating and fast bits are not ports, so writes are copied as they land
   always @(posedge clk) begin
      if (reset) begin
         misc5_q <= 8'h00;
         romCfg3_q <= 8'h00;
         busy_q <= 1'b0;
      end else begin
         if (apbWr && paddr == 12'h2cc) misc5_q <= pwdata[7:0];
         if (apbWr && paddr == 12'h2e0) romCfg3_q <= pwdata[7:0];
         if (take) busy_q <= 1'b1;
         else if (cycDone) busy_q <= 1'b0;
      end
      if (take) begin
         rom_q <= cycBiosRom | cycDosRom;
         fast_q <= fastNow;
      end
   end
   property p_stop; cpuClockStopped |=> biosRomSelectN && dosRomSelectN; endproperty
   a_stop: assert property (p_stop) else $error("rom select low with cpu clock stopped");
   property p_bios_gate; !misc5_q[2] && !biosRomSelectN |-> !(memRdCmdN && memWrCmdN); endproperty
   a_bios_gate: assert property (p_bios_gate) else $error("bios select without command");
   property p_dos_gate; !romCfg3_q[4] && !dosRomSelectN |-> !(memRdCmdN && memWrCmdN); endproperty
   a_dos_gate: assert property (p_dos_gate) else $error("dos select without command");
   property p_no_sel; busy_q && !rom_q |-> biosRomSelectN && dosRomSelectN; endproperty
   a_no_sel: assert property (p_no_sel) else $error("rom select in a non-rom cycle");
   property p_ale_fast; busy_q && fast_q && fullExpansionBusMode |-> !addrLatchEnable; endproperty
   a_ale_fast: assert property (p_ale_fast) else $error("latch enable in fast rom cycle");
   property p_ale_on; take && !(fastNow && fullExpansionBusMode) |=> addrLatchEnable; endproperty
   a_ale_on: assert property (p_ale_on) else $error("no latch enable at cycle start");
   property p_cmd_end; $rose(cmdIdle) |-> ##[0:2] cycDone; endproperty
   a_cmd_end: assert property (p_cmd_end) else $error("cycle end not at command release");
   property p_done; cycDone |-> cmdIdle; endproperty
   a_done: assert property (p_done) else $error("command still low at cycle end");
   property p_len; take |=> !cycDone [*5] ##[1:1000] cycDone; endproperty
   a_len: assert property (p_len) else $error("cycle length out of bounds");
   property p_delay; take |=> cmdIdle; endproperty
   a_delay: assert property (p_delay) else $error("command with the address");
   property p_apb; psel && $rose(penable) |=> pready; endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
   property p_unmapped; psel && $rose(penable) && paddr == 12'h000 |=> pready && pslverr; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
endmodule // bcwd_monitor
`default_nettype wire

// [verification/bcwd_rom_dev.sv]
// bcwd_rom_dev.sv: far-side rom and bus device that records each cycle's strobes
// assumes every cycle's start pulse clears the record
`timescale 1ns/1ps
`default_nettype none
module bcwd_rom_dev (
   input  wire logic       clk,      // clock
   input  wire logic       cycStart, // clears the record
   input  wire logic       ale,      // latch enable
   input  wire logic [3:0] cmdN,     // {iow, ior, memw, memr}
   input  wire logic [1:0] selN,     // {dos, bios}
   output int              cmdLen,   // clocks with a command low
   output logic [3:0]      cmdSeen,  // commands seen low
   output logic [1:0]      selSeen,  // selects seen low
   output logic            aleSeen,  // latch enable seen
   output logic            selFree   // select low with no command
);
   always @(posedge clk) begin
      if (cycStart) begin
         cmdLen <= 0;
         cmdSeen <= 4'h0;
         selSeen <= 2'h0;
         aleSeen <= 1'b0;
         selFree <= 1'b0;
      end else begin
         cmdLen <= cmdLen + (~&cmdN ? 1 : 0);
         cmdSeen <= cmdSeen | ~cmdN;
         selSeen <= selSeen | ~selN;
         aleSeen <= aleSeen | ale;
         selFree <= selFree | (~&selN & &cmdN); // a gated select never shows here
      end
   end
endmodule // bcwd_rom_dev
`default_nettype wire

// [verification/bus_cycle_wait_delay_control_tb.sv]
// bus_cycle_wait_delay_control_tb.sv: self-checking bench for the wait and delay sequencer
// assumes bcwd_ctrl with a short bus clock divide and the rom device model beside it
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_wait_delay_control_tb;
   localparam int DIV = 8; // short divide keeps slow cycles brief
   logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        cycStart = 1'b0, cycWrite = 1'b0, cycIo = 1'b0, cycWide = 1'b0;
   logic        cycBiosRom = 1'b0, cycDosRom = 1'b0, cycCard = 1'b0, cycWindow = 1'b0;
   logic [15:0] cycAddr = 16'h0;
   logic        cpuClockStopped = 1'b0, fullExpansionBusMode = 1'b0;
   wire  [31:0] prdata;
   wire         pready, pslverr, systemBusClock, addrLatchEnable, cycDone, memRdCmdN, memWrCmdN;
   wire         ioRdCmdN, ioWrCmdN, biosRomSelectN, dosRomSelectN;
   int          cmdLen, error_cnt = 0, samples_checked = 0;
   logic [3:0]  cmdSeen;
   logic [1:0]  selSeen;
   logic        aleSeen, selFree;
   logic [7:0]  rv [7];
   logic [11:0] ra [7] = '{12'h140, 12'h180, 12'h184, 12'h188, 12'h18c, 12'h2cc, 12'h2e0};
   bcwd_ctrl #(.SLOW_DIV(DIV)) DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .cycStart, .cycWrite, .cycIo, .cycWide, .cycBiosRom, .cycDosRom, .cycCard, .cycWindow, .cycAddr,
      .cpuClockStopped, .fullExpansionBusMode, .systemBusClock, .addrLatchEnable, .memRdCmdN, .memWrCmdN,
      .ioRdCmdN, .ioWrCmdN, .biosRomSelectN, .dosRomSelectN, .cycDone);
   bcwd_rom_dev dev (.clk, .cycStart, .ale(addrLatchEnable), .cmdN({ioWrCmdN, ioRdCmdN, memWrCmdN, memRdCmdN}),
      .selN({dosRomSelectN, biosRomSelectN}), .cmdLen, .cmdSeen, .selSeen, .aleSeen, .selFree);
   initial forever #2.5 clk = ~clk;
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // lo equal to hi is an exact four-state compare; ranges only ever see bench counts
   task automatic chk(input string s, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
      samples_checked++;
      if (lo == hi ? got !== lo : (got < lo || got > hi)) begin
         error_cnt++;
         $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
                      output logic e);
      int n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 1, 1, 0);
      @(posedge clk);
   endtask
   task automatic run(input int k);
      int ws, d, n, h, b;
      logic [15:0] a;
      logic [1:0] sel;
      logic fast, stop, full, wr;
      a = k == 6 ? 16'($urandom % 256) : 16'h100 + 16'($urandom % 768);
      if (k == 7 && $urandom % 2) a[15:3] = ($urandom % 2) ? 13'h7e : 13'h3e;
      stop = ($urandom % 5) == 0;
      full = 1'($urandom);
      wr = 1'($urandom);
      // no device here drives the 16-bit select, so fast 8-bit rom cycles are allowed
      fast = (k == 2 && rv[6][7]) || ((k == 3 || k == 4) && rv[5][6]);
      ws = 2 + rv[3][1:0];
      d = 1;
      case (k)
         0: d = rv[1][2] ? 1 : 2;
         1: begin
            ws = rv[0][5:3] > 3 ? ws : rv[0][5:3] + 1;
            d = rv[0][7] ? 0 : (rv[0][5] | rv[1][2]) ? 1 : 2;
         end
         2: begin
            ws = rv[0][2:0] > 3 ? ws : rv[0][2:0] + 1;
            d = rv[0][6] ? 0 : (rv[0][2] | rv[1][2]) ? 1 : 2;
         end
         3: ws = (rv[1][7] | rv[1][4]) ? 3 : 2;
         5: begin
            ws = 1 + rv[3][3:2];
            d = 0;
         end
         6: ws = rv[4][3] ? 4 : 2;
         7: begin
            ws = 2 + (a[15:3] == 13'h7e ? rv[2][1:0] : a[15:3] == 13'h3e ? rv[2][3:2] : rv[2][5:4]);
            d = rv[1][1:0] == 0 ? 1 : rv[1][1:0] == 1 ? 2 : 4;
         end
         8: ws = rv[4][2] ? 4 : 3;
         default: ;
      endcase
      if (fast) ws = 4 - (k == 2 ? rv[6][6:5] : rv[5][5:4]);
      h = fast ? 1 : DIV / 2;
      b = (4 + 2 * ws) * h;
      cycStart <= 1'b1;
      cycWrite <= wr;
      cycIo <= k > 5;
      cycWide <= k == 5 || k == 8;
      cycBiosRom <= k == 3 || k == 4;
      cycDosRom <= k == 2;
      cycCard <= k == 1;
      cycWindow <= k == 4;
      cycAddr <= a;
      cpuClockStopped <= stop;
      fullExpansionBusMode <= full;
      @(posedge clk);
      cycStart <= 1'b0;
      n = 0;
      while (cycDone !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      sel = stop ? 2'b00 : {k == 2, k == 3 || k == 4};
      chk("cycle length", b - h + 2, b + 3, n);
      if (!fast) chk("command length", (4 + 2 * ws - d) * h - (d ? 1 : h + 1), (4 + 2 * ws - d) * h + 1, cmdLen);
      chk("command lines", 1 << ((k > 5 ? 2 : 0) + wr), 1 << ((k > 5 ? 2 : 0) + wr), cmdSeen);
      chk("selects", sel, sel, selSeen);
      chk("select alone", (sel != 0) & (k == 2 ? rv[6][4] : rv[5][2]), (sel != 0) & (k == 2 ? rv[6][4] : rv[5][2]), selFree);
      chk("latch enable", !(fast & full & k != 2), !(fast & full & k != 2), aleSeen);
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      void'($urandom(92));
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, ra[i], 8'h00, r, e);
         chk("reset value", 0, 0, r);
      end
      @(posedge systemBusClock) repeat (DIV / 2 + 1) @(posedge clk);
      chk("bus clock", 0, 0, systemBusClock);
      for (int t = 0; t < 90; t++) begin
         for (int i = 0; i < 7; i++) begin
            rv[i] = 8'($urandom);
            apb(1'b1, ra[i], rv[i], r, e);
            chk("write error", 0, 0, e);
         end
         for (int i = 0; i < 7; i++) begin
            apb(1'b0, ra[i], 8'h00, r, e);
            chk("read back", rv[i], rv[i], r);
         end
         run(t % 9);
      end
      apb(1'b1, 12'h000, 8'hff, r, e);
      chk("unmapped error", 1, 1, e);
      apb(1'b0, ra[0], 8'h00, r, e);
      chk("after refused write", rv[0], rv[0], r);
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      end_of_test();
   end
endmodule // bus_cycle_wait_delay_control_tb
bind bcwd_ctrl bcwd_monitor #(.SLOW_DIV(SLOW_DIV)) mon (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .cycStart, .cycIo, .cycBiosRom, .cycDosRom, .cpuClockStopped, .fullExpansionBusMode,
   .addrLatchEnable, .memRdCmdN, .memWrCmdN, .ioRdCmdN, .ioWrCmdN, .biosRomSelectN, .dosRomSelectN, .cycDone);
`default_nettype wire
